// ### src/pcs_top.sv
/*
  Control and status signals of four PC Card sockets plus a small card cycle engine,
  reached over AXI4-Lite.
  Assumes socket inputs are asynchronous pins; shared address/data buses live elsewhere.
*/
// Function
// - drive per-socket active-low write strobe during memory writes
// - the same strobe acts as program strobe for programmable memory cards
// - ready/irq input means ready/busy for memory, interrupt for I/O cards
// - status register shows live ready/irq and write-protect/port-width levels
// - writes blocked by write-protect only when window protect bit is one
// - port-width decides how many card cycles a host transfer needs
// - 16-bit I/O without port-width becomes two byte cycles, even then odd
// - per-socket reset output holds the card in hard reset
// - card wait stretches the running cycle until released
// - even enable selects even bytes, odd enable selects odd bytes
// - four sockets with identical per-socket signal sets; memory read and I/O strobes are shared
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defines.svh"

module pcs_top (
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // axi4-lite write
  input  wire logic [`PCS_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // axi4-lite read
  input  wire logic [`PCS_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // per-socket card pins
  output logic [3:0]                   card_write_strobe_n,
  output logic [3:0]                   card_enable_even_n,
  output logic [3:0]                   card_enable_odd_n,
  output logic [3:0]                   card_reset,
  input  wire logic [3:0]              card_ready_busy_n,
  input  wire logic [3:0]              card_port_wide_n,
  input  wire logic [3:0]              card_wait_n,
  // common card strobes
  output logic                         card_oe_n,
  output logic                         card_io_rd_n,
  output logic                         card_io_wr_n,
  // interrupt
  output logic                         irq
);
  import pcs_pkg::*;

  pcs_state_s r;
  pcs_state_s n;

  logic [31:0] wmask;
  logic [31:0] wval;
  logic [31:0] ctrl_img;
  logic        ev;
  logic        od;
  logic        sel;

  assign ctrl_img = {20'h0, r.wp_en, r.rst, r.io_type};

  always_comb begin
    n = r;
    wmask = {{8{r.wstrb[3]}}, {8{r.wstrb[2]}}, {8{r.wstrb[1]}}, {8{r.wstrb[0]}}};
    wval = 32'h0;
    ev = 1'b0;
    od = 1'b0;
    sel = 1'b0;
    // second stage reads only the first; nothing else looks at s1_*
    n.s1_rdy = card_ready_busy_n;
    n.s2_rdy = r.s1_rdy;
    n.s1_wp = card_port_wide_n;
    n.s2_wp = r.s1_wp;
    n.s1_wt = card_wait_n;
    n.s2_wt = r.s1_wt;
    n.rdy_d = r.s2_rdy;

    // write channel: address and data taken in either order
    if (s_axi_awvalid && r.awready) begin
      n.awg = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready) begin
      n.wg = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (r.awg && r.wg && !r.bvalid) begin
      n.awg = 1'b0;
      n.wg = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `PCS_RESP_OKAY;
      case (r.awaddr)
        `PCS_OFS_CTRL: begin
          wval = (ctrl_img & ~wmask) | (r.wdata & wmask);
          n.io_type = wval[`PCS_CTRL_IO_LSB +: 4];
          n.rst = wval[`PCS_CTRL_RST_LSB +: 4];
          n.wp_en = wval[`PCS_CTRL_WPE_LSB +: 4];
        end
        `PCS_OFS_CMD: begin
          // a command while a cycle runs is refused rather than queued
          if (r.st != ST_IDLE || !r.wstrb[0]) begin
            n.bresp = `PCS_RESP_SLVERR;
          end else begin
            n.sock = r.wdata[`PCS_CMD_SOCK_LSB +: 2];
            n.io = r.wdata[`PCS_CMD_IO_BIT];
            n.wr = r.wdata[`PCS_CMD_WR_BIT];
            n.wide = r.wdata[`PCS_CMD_WIDE_BIT];
            n.odd = r.wdata[`PCS_CMD_ODD_BIT];
            n.split = 1'b0;
            n.second = 1'b0;
            n.blk = 1'b0;
            n.nbytes = 2'h0;
            n.st = ST_SETUP;
            n.cnt = 4'(`PCS_SETUP_CYC - 1);
          end
        end
        `PCS_OFS_ISTAT: begin
          if (r.wstrb[0]) begin
            n.istat = r.istat & ~r.wdata[5:0];
          end
        end
        `PCS_OFS_IMASK: begin
          if (r.wstrb[0]) begin
            n.imask = r.wdata[5:0];
          end
        end
        `PCS_OFS_STAT: ;
        default: n.bresp = `PCS_RESP_SLVERR;
      endcase
    end

    // read channel
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r.arready) begin
      n.rvalid = 1'b1;
      n.rresp = `PCS_RESP_OKAY;
      case (s_axi_araddr)
        `PCS_OFS_CTRL:  n.rdata = ctrl_img;
        `PCS_OFS_CMD:   n.rdata = {26'h0, r.odd, r.wide, r.wr, r.io, r.sock};
        `PCS_OFS_STAT:  n.rdata = {20'h0, r.nbytes, r.blk, r.st != ST_IDLE,
                                   r.s2_wp, r.s2_rdy};
        `PCS_OFS_ISTAT: n.rdata = {26'h0, r.istat};
        `PCS_OFS_IMASK: n.rdata = {26'h0, r.imask};
        default: begin
          n.rdata = 32'h0;
          n.rresp = `PCS_RESP_SLVERR;
        end
      endcase
    end

    // card cycle engine
    unique case (r.st)
      ST_IDLE: ;
      ST_SETUP: begin
        if (r.cnt != 4'h0) begin
          n.cnt = r.cnt - 4'h1;
        end else begin
          if (!r.second) begin
            n.split = r.io && r.wide && r.s2_wp[r.sock];
            n.blk = !r.io && r.wr && r.wp_en[r.sock] && r.s2_wp[r.sock];
          end
          n.st = ST_STRB;
          n.cnt = 4'(`PCS_STRB_CYC - 1);
        end
      end
      ST_STRB: begin
        if (r.cnt != 4'h0) begin
          n.cnt = r.cnt - 4'h1;
        end else if (r.s2_wt[r.sock]) begin
          n.st = ST_HOLD;
          n.cnt = 4'(`PCS_HOLD_CYC - 1);
          n.nbytes = r.nbytes + 2'h1;
        end
      end
      ST_HOLD: begin
        if (r.cnt != 4'h0) begin
          n.cnt = r.cnt - 4'h1;
        end else if (r.split && !r.second) begin
          n.second = 1'b1;
          n.st = ST_SETUP;
          n.cnt = 4'(`PCS_SETUP_CYC - 1);
        end else begin
          n.st = ST_IDLE;
        end
      end
    endcase

    // sticky events; a set in the same cycle as a clear wins
    for (int k = 0; k < 4; k++) begin
      if (r.io_type[k] ? !r.s2_rdy[k] : (r.s2_rdy[k] && !r.rdy_d[k])) begin
        n.istat[k] = 1'b1;
      end
    end
    if (r.st == ST_HOLD && n.st == ST_IDLE) begin
      n.istat[`PCS_IST_DONE_BIT] = 1'b1;
      // built on the cleared image so a clear in this cycle is not undone
      n.istat[`PCS_IST_BLK_BIT] = n.istat[`PCS_IST_BLK_BIT] | r.blk;
    end
    n.irq = |(n.istat & n.imask);

    // pin images follow the next state so they change with it
    for (int k = 0; k < 4; k++) begin
      sel = (n.st != ST_IDLE) && (n.sock == 2'(k));
      if (n.split) begin
        ev = !n.second;
        od = n.second;
      end else begin
        ev = n.wide || !n.odd;
        od = n.wide || n.odd;
      end
      n.ce_even_n[k] = !(sel && ev);
      n.ce_odd_n[k] = !(sel && od);
      // one pin serves both write and program strobes
      n.we_n[k] = !(sel && n.st == ST_STRB && n.wr && !n.io && !n.blk);
    end
    n.oe_n = !(n.st == ST_STRB && !n.wr && !n.io);
    n.iord_n = !(n.st == ST_STRB && !n.wr && n.io);
    n.iowr_n = !(n.st == ST_STRB && n.wr && n.io);

    n.awready = !n.awg && !n.bvalid;
    n.wready = !n.wg && !n.bvalid;
    n.arready = !n.rvalid;

    if (!aresetn) begin
      n = '0;
      n.st = ST_IDLE;
      n.rst = `PCS_RST_CARD_RESET;
      n.imask = `PCS_RST_IMASK;
      n.we_n = 4'hF;
      n.ce_even_n = 4'hF;
      n.ce_odd_n = 4'hF;
      n.oe_n = 1'b1;
      n.iord_n = 1'b1;
      n.iowr_n = 1'b1;
      n.s1_rdy = 4'hF;
      n.s2_rdy = 4'hF;
      n.rdy_d = 4'hF;
      n.s1_wt = 4'hF;
      n.s2_wt = 4'hF;
    end
  end

  always_ff @(posedge aclk) begin
    r <= n;
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bresp = r.bresp;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_arready = r.arready;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rvalid = r.rvalid;
  assign card_write_strobe_n = r.we_n;
  assign card_enable_even_n = r.ce_even_n;
  assign card_enable_odd_n = r.ce_odd_n;
  assign card_reset = r.rst;
  assign card_oe_n = r.oe_n;
  assign card_io_rd_n = r.iord_n;
  assign card_io_wr_n = r.iowr_n;
  assign irq = r.irq;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  strobe_mem_a: assert property (
    card_write_strobe_n != 4'hF |-> r.st == ST_STRB && r.wr && !r.io && !r.blk)
    else $error("write strobe outside a memory write");
  wp_block_a: assert property (
    (r.st == ST_SETUP && r.cnt == 4'h0 && !r.second && !r.io && r.wr
     && r.wp_en[r.sock] && r.s2_wp[r.sock]) |=> r.st == ST_STRB ##0 card_write_strobe_n == 4'hF)
    else $error("protected write not blocked");
  status_lvl_a: assert property (
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == `PCS_OFS_STAT)
    |=> s_axi_rdata[7:0] == {$past(r.s2_wp), $past(r.s2_rdy)})
    else $error("status levels wrong");
  for (genvar g = 0; g < 4; g++) begin : g_irq
    irq_type_a: assert property (
      (r.io_type[g] && !r.s2_rdy[g]) |=> r.istat[g])
      else $error("io card interrupt lost");
    mem_ready_a: assert property (
      (!r.io_type[g] && r.s2_rdy[g] && !r.rdy_d[g]) |=> r.istat[g])
      else $error("memory ready event lost");
  end
  split_order_a: assert property (
    (r.st == ST_STRB && r.split) |-> (r.second ? card_enable_even_n == 4'hF
                                              : card_enable_odd_n == 4'hF))
    else $error("byte split order wrong");
  wait_hold_a: assert property (
    (r.st == ST_STRB && r.cnt == 4'h0 && !r.s2_wt[r.sock]) |=> r.st == ST_STRB)
    else $error("cycle ended under wait");
  width_cnt_a: assert property (
    (r.st == ST_HOLD && r.cnt == 4'h0 && !(r.split && !r.second))
    |=> r.st == ST_IDLE && r.nbytes == (r.split ? 2'h2 : 2'h1))
    else $error("card cycle count wrong");
  reset_out_a: assert property (
    (r.awg && r.wg && !r.bvalid && r.awaddr == `PCS_OFS_CTRL && r.wstrb[0])
    |=> card_reset == $past(r.wdata[7:4]))
    else $error("card reset not updated");
  sock_iso_a: assert property (
    ((~card_enable_even_n | ~card_enable_odd_n) & ~(4'h1 << r.sock)) == 4'h0)
    else $error("enable on unselected socket");
  narrow_byte_a: assert property (
    (r.st != ST_IDLE && !r.split && !r.wide) |-> (r.odd ? card_enable_even_n == 4'hF
                                                       : card_enable_odd_n == 4'hF))
    else $error("narrow cycle on wrong byte");
  reset_hold_a: assert property (
    !(r.awg && r.wg && !r.bvalid && r.awaddr == `PCS_OFS_CTRL) |=> $stable(card_reset))
    else $error("card reset changed without a write");
  blk_event_a: assert property (
    (r.st == ST_HOLD && r.cnt == 4'h0 && r.blk) |=> r.istat[`PCS_IST_BLK_BIT])
    else $error("blocked write not flagged");
  done_flag_a: assert property (
    (r.st == ST_HOLD && r.cnt == 4'h0 && !(r.split && !r.second))
    |=> r.istat[`PCS_IST_DONE_BIT])
    else $error("cycle end not flagged");

endmodule
`default_nettype wire

// ### include/pcs_defines.svh
/*
  Offsets, field positions, reset values and cycle timing for the socket control block.
  Assumes a 50 MHz aclk and AXI4-Lite byte addresses in the low 8 bits.
*/
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH

`define PCS_ADDR_W     8
`define PCS_OFS_CTRL   8'h00
`define PCS_OFS_CMD    8'h04
`define PCS_OFS_STAT   8'h08
`define PCS_OFS_ISTAT  8'h0C
`define PCS_OFS_IMASK  8'h10

`define PCS_RESP_OKAY   2'h0
`define PCS_RESP_SLVERR 2'h2

// ctrl fields
`define PCS_CTRL_IO_LSB  0
`define PCS_CTRL_RST_LSB 4
`define PCS_CTRL_WPE_LSB 8
// cmd fields
`define PCS_CMD_SOCK_LSB 0
`define PCS_CMD_IO_BIT   2
`define PCS_CMD_WR_BIT   3
`define PCS_CMD_WIDE_BIT 4
`define PCS_CMD_ODD_BIT  5
// interrupt status fields
`define PCS_IST_DONE_BIT 4
`define PCS_IST_BLK_BIT  5

`define PCS_RST_CARD_RESET 4'hF
`define PCS_RST_IMASK      6'h00

`define PCS_CLK_NS   20
`define PCS_SETUP_NS 20
`define PCS_STRB_NS  100
`define PCS_HOLD_NS  20
`define PCS_SETUP_CYC ((`PCS_SETUP_NS + `PCS_CLK_NS - 1) / `PCS_CLK_NS)
`define PCS_STRB_CYC  ((`PCS_STRB_NS + `PCS_CLK_NS - 1) / `PCS_CLK_NS)
`define PCS_HOLD_CYC  ((`PCS_HOLD_NS + `PCS_CLK_NS - 1) / `PCS_CLK_NS)

`endif

// ### include/pcs_pkg.sv
/*
  Types for the socket control block: cycle engine states and the packed state record.
  Assumes pcs_defines.svh is not needed here; widths are literal.
*/
`default_nettype none
package pcs_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STRB, ST_HOLD} pcs_state_e;

  typedef struct packed {
    logic        awready, wready, arready, awg, wg, bvalid, rvalid, irq;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [3:0]  io_type, rst, wp_en;
    logic [5:0]  imask, istat;
    logic [3:0]  s1_rdy, s2_rdy, s1_wp, s2_wp, s1_wt, s2_wt, rdy_d;
    pcs_state_e  st;
    logic [3:0]  cnt;
    logic [1:0]  sock, nbytes;
    logic        io, wr, wide, odd, split, second, blk;
    logic [3:0]  we_n, ce_even_n, ce_odd_n;
    logic        oe_n, iord_n, iowr_n;
  } pcs_state_s;
endpackage
`default_nettype wire

// ### testbench/pcs_card_model.sv
/*
  Behavioural card for one socket: memory (busy after writes, write protect) or I/O
  (interrupt request, 16-bit port), with optional wait stretching.
  Assumes one instance per socket, sampling on the host clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pcs_card_model (
  // settings from the bench
  input  wire logic aclk,
  input  wire logic is_io,
  input  wire logic irq_req,
  input  wire logic wp_on,
  input  wire logic wide,
  input  wire logic stall,
  // socket pins
  input  wire logic we_n,
  input  wire logic ce_e_n,
  input  wire logic ce_o_n,
  input  wire logic rst,
  output logic      rdy_n,
  output logic      pw_n,
  output logic      wait_n
);
  logic [3:0] busy  = 4'h0;
  logic [3:0] hold  = 4'h0;
  logic       we_d  = 1'b1;
  logic       sel_d = 1'b0;
  wire  logic sel   = !(ce_e_n && ce_o_n);

  always @(posedge aclk) begin
    we_d  <= we_n;
    sel_d <= sel;
    if (rst)
      busy <= 4'h0;
    else if (!we_d && we_n)
      busy <= 4'h6; // busy after each write, unless held in reset
    else if (busy != 4'h0)
      busy <= busy - 4'h1;
    if (stall && sel && !sel_d)
      hold <= 4'h4;
    else if (hold != 4'h0)
      hold <= hold - 4'h1;
  end
  // ready only once the six-cycle busy count after a write has run out
  assign rdy_n  = is_io ? !irq_req : (busy == 4'h0);
  // no address bus here, so an I/O card treats every access as its own port
  assign pw_n   = is_io ? !wide : wp_on;
  assign wait_n = (hold == 4'h0);
endmodule
`default_nettype wire

// ### testbench/tb_pcs_top.sv
/*
  Self-checking bench for pcs_top: register access, card cycle shapes, status and irq.
  Assumes four pcs_card_model instances on the socket pins, bready/rready held high.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defines.svh"

module tb_pcs_top;
  logic            aclk = 1'b0;
  logic            aresetn = 1'b0;
  logic [7:0]      awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]     wdata = 32'h0, d;
  logic [3:0]      wstrb = 4'h0;
  logic            awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [3:0]      is_io = 4'h2, irq_req = 4'h0, wp_on = 4'h4, wide = 4'h0, stall = 4'h0;
  wire logic       awready, wready, bvalid, arready, rvalid, oe_n, io_rd_n, io_wr_n, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [3:0] we_n, ce_e_n, ce_o_n, card_reset, rdy_n, pw_n, wait_n;
  logic [1:0]      r, r2, r3;
  logic [6:0][7:0] cnt;
  int              n_checks = 0, n_mismatch = 0, fe, fo, oth;

  always #10 aclk = ~aclk;

  pcs_top i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .card_write_strobe_n(we_n), .card_enable_even_n(ce_e_n), .card_enable_odd_n(ce_o_n),
    .card_reset(card_reset), .card_ready_busy_n(rdy_n), .card_port_wide_n(pw_n),
    .card_wait_n(wait_n), .card_oe_n(oe_n), .card_io_rd_n(io_rd_n), .card_io_wr_n(io_wr_n),
    .irq(irq));

  pcs_card_model i_card [3:0] (
    .aclk(aclk), .is_io(is_io), .irq_req(irq_req), .wp_on(wp_on), .wide(wide),
    .stall(stall), .we_n(we_n), .ce_e_n(ce_e_n), .ce_o_n(ce_o_n), .rst(card_reset),
    .rdy_n(rdy_n), .pw_n(pw_n), .wait_n(wait_n));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic tmo(input int n);
    if (n >= 60) begin
      n_mismatch++;
      $display("unexpected at %0t: bus wait ran out", $time);
      stop_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                    output logic [1:0] rsp);
    int n;
    bit pa, pw;
    n = 0;
    pa = 1;
    pw = 1;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while ((pa || pw) && n < 60) begin
      @(posedge aclk);
      n++;
      if (pa && awready) begin
        pa = 0;
        awvalid <= 1'b0;
      end
      if (pw && wready) begin
        pw = 0;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid && n < 60) begin
      @(posedge aclk);
      n++;
    end
    rsp = bresp;
    tmo(n);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rsp);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!arready && n < 60);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!rvalid && n < 60);
    v = rdata;
    rsp = rresp;
    tmo(n);
  endtask

  // counts low cycles per strobe kind while the command runs, from the bench's side
  task automatic run(input logic [7:0] c);
    logic [1:0] rsp;
    logic       e, o;
    int         s;
    s = c[1:0];
    cnt = '0;
    fe = -1;
    fo = -1;
    oth = 0;
    fork
      wr(`PCS_OFS_CMD, {24'h0, c}, 4'hF, rsp);
      for (int i = 0; i < 40; i++) begin
        @(posedge aclk);
        e = !ce_e_n[s];
        o = !ce_o_n[s];
        cnt[6] += 8'(e & ~o);
        cnt[5] += 8'(o & ~e);
        cnt[4] += 8'(e & o);
        cnt[3] += 8'(!we_n[s]);
        cnt[2] += 8'(!oe_n);
        cnt[1] += 8'(!io_rd_n);
        cnt[0] += 8'(!io_wr_n);
        if (e && !o && fe < 0)
          fe = i;
        if (o && !e && fo < 0)
          fo = i;
        if (((~we_n | ~ce_e_n | ~ce_o_n) & ~(4'h1 << s)) != 4'h0)
          oth++;
      end
    join
    chk(rsp, `PCS_RESP_OKAY, "command write");
    chk(oth, 0, "idle sockets quiet");
  endtask

  task automatic cyc(input logic [7:0] c, input logic [55:0] x);
    run(c);
    chk(cnt, x, "cycle shape");
  endtask

  // register map basics and the card reset field
  task automatic t_regs();
    rd(`PCS_OFS_CTRL, d, r);
    chk({r, d}, {2'h0, 32'h000000F0}, "ctrl after reset");
    chk(card_reset, 4'hF, "reset pins");
    rd(8'h40, d, r);
    chk({r, d}, {2'h2, 32'h0}, "unmapped read");
    wr(8'h40, 32'h1, 4'hF, r);
    wr(`PCS_OFS_STAT, 32'h0, 4'hF, r2);
    wr(`PCS_OFS_CMD, 32'h8, 4'h0, r3);
    chk({r, r2, r3}, 6'h22, "refused writes");
    wr(`PCS_OFS_CTRL, 32'h482, 4'hF, r);
    repeat (2) @(posedge aclk);
    chk(card_reset, 4'h8, "reset released");
  endtask

  task automatic t_mem_write();
    wr(`PCS_OFS_ISTAT, 32'h3F, 4'hF, r);
    cyc(8'h08, 56'h07000005000000);
    repeat (20) @(posedge aclk);
    rd(`PCS_OFS_ISTAT, d, r);
    chk(d, 32'h11, "done then ready");
  endtask

  task automatic t_wait();
    stall <= 4'h1;
    run(8'h08);
    chk(cnt[3] >= 8'h07, 1'b1, "stretched strobe");
    stall <= 4'h0;
  endtask

  // width is only known at the end of setup, so a split starts with both enables for one cycle
  task automatic t_io();
    wide <= 4'h2;
    cyc(8'h15, 56'h00000700000500);
    wide <= 4'h0;
    cyc(8'h1D, 56'h0607010000000A);
    chk(fe < fo, 1'b1, "even byte first");
    rd(`PCS_OFS_STAT, d, r);
    chk(d[11:8], 4'h8, "two card cycles");
    cyc(8'h25, 56'h00070000000500);
  endtask

  task automatic t_protect();
    wp_on <= 4'hC;
    run(8'h0A);
    chk(cnt[3], 8'h00, "protected write");
    rd(`PCS_OFS_STAT, d, r);
    chk(d[9], 1'b1, "blocked flag");
    cyc(8'h0B, 56'h07000005000000);
    cyc(8'h03, 56'h07000000050000);
  endtask

  task automatic t_irq();
    irq_req <= 4'h2;
    repeat (12) @(posedge aclk);
    rd(`PCS_OFS_STAT, d, r);
    chk(d[7:0], 8'hED, "live pin levels");
    wr(`PCS_OFS_IMASK, 32'h2, 4'hF, r);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b1, "irq raised");
    wr(`PCS_OFS_IMASK, 32'h0, 4'hF, r);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0, "irq masked");
    irq_req <= 4'h0;
    repeat (4) @(posedge aclk);
    wr(`PCS_OFS_ISTAT, 32'h3F, 4'hF, r);
    rd(`PCS_OFS_ISTAT, d, r);
    chk(d, 32'h0, "events cleared");
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    t_regs();
    t_mem_write();
    t_wait();
    t_io();
    t_protect();
    t_irq();
    stop_test();
  end
endmodule
`default_nettype wire
